// >>> core/ddm_defines.vh
// Purpose: Constants for the diagnostic trouble code monitor
// Assumes: 125 MHz clock
// Notes:   Register indices, field positions, reset values, timing
`ifndef DDM_DEFINES_VH
`define DDM_DEFINES_VH
// Register indices (word address = index)
`define DDM_REG_SEL        6'h00
`define DDM_REG_CFG        6'h01
`define DDM_REG_THR_LO     6'h02
`define DDM_REG_THR_HI     6'h03
`define DDM_REG_THR_LO2    6'h04
`define DDM_REG_THR_HI2    6'h05
`define DDM_REG_SPN0       6'h06
`define DDM_REG_SPN1       6'h07
`define DDM_REG_SPN2       6'h08
`define DDM_REG_SPN3       6'h09
`define DDM_REG_DLY        6'h0a
`define DDM_REG_CTRL       6'h0b
`define DDM_REG_ACTIVE     6'h0c
`define DDM_REG_PREV       6'h0d
`define DDM_REG_OCC        6'h0e
`define DDM_REG_STATUS     6'h0f
`define DDM_REG_DTC        6'h10
// Config field positions
`define DDM_CFG_STYLE_LO   0
`define DDM_CFG_SRC_LO     2
`define DDM_CFG_LATCH_BIT  6
`define DDM_CFG_LAMP_LO    7
`define DDM_CFG_GEN_LO     9
// Sources
`define DDM_SRC_SUPPLY     4'h0
`define DDM_SRC_TEMP       4'h1
`define DDM_SRC_TIMEOUT    4'h2
`define DDM_SRC_CURR0      4'h3
// Styles
`define DDM_STY_MINMAX     2'h0
`define DDM_STY_ABS        2'h1
`define DDM_STY_STATE      2'h2
`define DDM_STY_DOUBLE     2'h3
// Reset values
`define DDM_CFG_RST_ABS    13'h1e85
`define DDM_CFG_RST_MINMAX 13'h1e80
`define DDM_CFG_RST_STATE  13'h1e8a
`define DDM_CFG_RST_SUP    13'h1e80
`define DDM_FMI_MAX        5'h15
`define DDM_FMI_EXISTS     5'h1f
// Timing
`define DDM_CLK_MHZ        125
`define DDM_HOLDOFF_S      5
`define DDM_MS_CYCLES      125000
`endif

// >>> core/ddm_monitor.v
// Purpose: Sixteen diagnostic definitions with DTC activation and DM1 cues
// Assumes: Inputs synchronous; CAN framing done by an outside transmitter
// Notes:   Occurrence log held in flip-flops; retention supply assumed
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "ddm_defines.vh"

// Function
// - DTC is SPN, FMI, CM, OC bytes
// - Sixteen independently configured definitions
// - Definitions 1-3 default supply, temp, timeout
// - Four styles selectable per definition
// - Window style quiet between thresholds
// - Absolute style quiet below threshold
// - State style uses fixed one/zero thresholds
// - Double style compares four thresholds
// - Output current diagnostics set output flags
// - Supply and temp flags disable outputs
// - DM1 on activation and last clear
// - Several active codes use multipacket
// - No DM1 for five seconds after reset
// - Qualify delay, activate, count, send DM1
// - Cleared condition moves code to previous
// - Latch option holds until active clear
// - Lamp selection placed in first byte
// - Zero SPN sends no diagnostic message
// - SPN change zeroes occurrence count
// - FMI accepted 0 to 21 or 31
// - Previous list sent only on request
// - Previous data cleared only on request
// - Over temperature keeps outputs disabled
module ddm_monitor
#(
  parameter HOLDOFF_MS = 5000,
  parameter MS_CYCLES  = `DDM_MS_CYCLES
)
(
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Register port
  input  wire [5:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Monitored values
  input  wire [15:0] supply_value,
  input  wire [15:0] temp_value,
  input  wire [3:0]  timeout_flags,
  input  wire [63:0] current_value,
  // Network requests
  input  wire        dm2_request,
  input  wire        dm3_request,
  input  wire        dm11_request,
  // Message cues to transmitter
  output reg         dm1_send,
  output reg         dm1_multipacket,
  output reg         dm2_send,
  output reg  [1:0]  lamp_status,
  // Fault flags
  output reg  [3:0]  output_fault,
  output reg         supply_fault,
  output reg         temp_fault,
  output wire        outputs_off
);

  // ==========================================================
  // Storage
  // sixteen definition slots
  reg [12:0] cfg      [0:15];
  reg [15:0] thr_lo   [0:15];
  reg [15:0] thr_hi   [0:15];
  reg [15:0] thr_lo2  [0:15];
  reg [15:0] thr_hi2  [0:15];
  reg [18:0] spn      [0:3][0:15];
  reg [15:0] dly      [0:15];
  reg [15:0] cnt      [0:15];
  reg [7:0]  occ      [0:15];
  reg [1:0]  zone     [0:15];
  reg [15:0] active;
  reg [15:0] prev;
  reg [3:0]  sel;
  reg [1:0]  fsel;
  reg        pwr_dis_en;
  reg        temp_dis_en;
  reg [16:0] ms_cnt;
  reg [12:0] hold_cnt;
  reg        holdoff_done;
  reg [15:0] pending;
  integer    i;
  integer    j;
  integer    k;
  integer    m;
  integer    n;

  // ==========================================================
  // Helpers
  function [15:0] pick_value;
    input [3:0]  src;
    input [15:0] sv;
    input [15:0] tv;
    input [3:0]  to;
    input [63:0] cv;
    begin
      case (src)
        `DDM_SRC_SUPPLY:  pick_value = sv;
        `DDM_SRC_TEMP:    pick_value = tv;
        `DDM_SRC_TIMEOUT: pick_value = {15'h0000, |to};
        4'h3:             pick_value = cv[15:0];
        4'h4:             pick_value = cv[31:16];
        4'h5:             pick_value = cv[47:32];
        4'h6:             pick_value = cv[63:48];
        default:          pick_value = 16'h0000;
      endcase
    end
  endfunction

  // Zone 0 = quiet, 1..3 = which threshold tripped (maps to SPN set)
  function [1:0] eval_zone;
    input [1:0]  sty;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    input [15:0] lo2;
    input [15:0] hi2;
    begin
      eval_zone = 2'h0;
      case (sty)
        `DDM_STY_MINMAX:
          if (v < lo) eval_zone = 2'h1;
          else if (v > hi) eval_zone = 2'h2;
        `DDM_STY_ABS:
          if (v >= lo) eval_zone = 2'h1;
        `DDM_STY_STATE:
          if (v == 16'h0001) eval_zone = 2'h1;
        default:
          if (v < lo2) eval_zone = 2'h3;
          else if (v < lo) eval_zone = 2'h1;
          else if (v > hi2) eval_zone = 2'h3;
          else if (v > hi) eval_zone = 2'h2;
      endcase
    end
  endfunction

  function fmi_ok;
    input [4:0] f;
    begin
      fmi_ok = (f <= `DDM_FMI_MAX) || (f == `DDM_FMI_EXISTS);
    end
  endfunction

  // ==========================================================
  // Evaluation
  reg [1:0]  next_zone [0:15];
  reg [15:0] raw_fault;
  reg [15:0] reportable;
  always @*
  begin
    for (k = 0; k < 16; k = k + 1)
    begin
      next_zone[k] = eval_zone(cfg[k][1:0],
        pick_value(cfg[k][5:2], supply_value, temp_value,
                   timeout_flags, current_value),
        thr_lo[k], thr_hi[k], thr_lo2[k], thr_hi2[k]);
      raw_fault[k] = (next_zone[k] != 2'h0);
      reportable[k] = (spn[0][k] != 19'h00000)
        && cfg[k][`DDM_CFG_GEN_LO];
    end
  end

  // ==========================================================
  // Power-up holdoff
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_cnt       <= 17'h00000;
      hold_cnt     <= 13'h0000;
      holdoff_done <= 1'b0;
    end
    else
    begin
      if (ms_cnt == MS_CYCLES - 1)
      begin
        ms_cnt <= 17'h00000;
        if (hold_cnt == HOLDOFF_MS - 1)
          holdoff_done <= 1'b1;
        else if (!holdoff_done)
          hold_cnt <= hold_cnt + 13'h0001;
      end
      else
        ms_cnt <= ms_cnt + 17'h00001;
    end
  end
  // Tick keeps running so delays stay in milliseconds after holdoff
  wire ms_tick = (ms_cnt == MS_CYCLES - 1);

  // ==========================================================
  // Qualification, activation, logging, register writes
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active      <= 16'h0000;
      prev        <= 16'h0000;
      pending     <= 16'h0000;
      sel         <= 4'h0;
      fsel        <= 2'h0;
      pwr_dis_en  <= 1'b0;
      temp_dis_en <= 1'b0;
      for (i = 0; i < 16; i = i + 1)
      begin
        cfg[i]     <= (i == 0) ? `DDM_CFG_RST_SUP :
                      (i == 1) ? `DDM_CFG_RST_ABS :
                      (i == 2) ? `DDM_CFG_RST_STATE :
                      `DDM_CFG_RST_MINMAX;
        // Absolute default must not trip at reset
        thr_lo[i]  <= (i == 1) ? 16'hffff : 16'h0000;
        thr_hi[i]  <= 16'hffff;
        thr_lo2[i] <= 16'h0000;
        thr_hi2[i] <= 16'hffff;
        dly[i]     <= 16'h0000;
        cnt[i]     <= 16'h0000;
        zone[i]    <= 2'h0;
        for (j = 0; j < 4; j = j + 1)
          spn[j][i] <= 19'h00000;
      end
    end
    else
    begin
      pending <= 16'h0000;
      for (i = 0; i < 16; i = i + 1)
      begin
        if (!raw_fault[i] || next_zone[i] != zone[i])
          cnt[i] <= dly[i];
        else if (cnt[i] != 16'h0000 && ms_tick)
          cnt[i] <= cnt[i] - 16'h0001;
        zone[i] <= next_zone[i];
        if (raw_fault[i] && next_zone[i] == zone[i]
            && cnt[i] == 16'h0000 && !active[i] && reportable[i])
        begin
          active[i]  <= 1'b1;
          pending[i] <= 1'b1;
        end
        else if (!raw_fault[i] && active[i]
                 && !cfg[i][`DDM_CFG_LATCH_BIT])
        begin
          active[i] <= 1'b0;
          prev[i]   <= 1'b1;
        end
      end
      if (dm11_request)
        for (i = 0; i < 16; i = i + 1)
          if (!raw_fault[i] && active[i])
          begin
            active[i] <= 1'b0;
            prev[i]   <= 1'b1;
          end
      if (dm3_request)
        for (i = 0; i < 16; i = i + 1)
          // Code moving to previous this cycle keeps its bit
          if (!(active[i] && !raw_fault[i]
                && (!cfg[i][`DDM_CFG_LATCH_BIT] || dm11_request)))
            prev[i] <= 1'b0;
      if (reg_wr)
      begin
        if (reg_addr == `DDM_REG_SEL)
        begin
          sel  <= reg_wdata[3:0];
          fsel <= reg_wdata[5:4];
        end
        else if (reg_addr == `DDM_REG_CFG)
        begin
          if (fmi_ok(reg_wdata[20:16]) && fmi_ok(reg_wdata[25:21]))
            cfg[sel] <= reg_wdata[12:0];
        end
        else if (reg_addr == `DDM_REG_THR_LO)
          thr_lo[sel] <= reg_wdata[15:0];
        else if (reg_addr == `DDM_REG_THR_HI)
          thr_hi[sel] <= reg_wdata[15:0];
        else if (reg_addr == `DDM_REG_THR_LO2)
          thr_lo2[sel] <= reg_wdata[15:0];
        else if (reg_addr == `DDM_REG_THR_HI2)
          thr_hi2[sel] <= reg_wdata[15:0];
        else if (reg_addr >= `DDM_REG_SPN0
                 && reg_addr <= `DDM_REG_SPN3)
        begin
          if (fmi_ok(reg_wdata[23:19]))
            spn[reg_addr[1:0] - 2'h2][sel] <= reg_wdata[18:0];
        end
        else if (reg_addr == `DDM_REG_DLY)
          dly[sel] <= reg_wdata[15:0];
        else if (reg_addr == `DDM_REG_CTRL)
        begin
          pwr_dis_en  <= reg_wdata[0];
          temp_dis_en <= reg_wdata[1];
        end
      end
    end
  end

  // ==========================================================
  // Failure mode store and occurrence log
  reg [4:0] fmi [0:3][0:15];
  wire spn_wr = reg_wr && reg_addr >= `DDM_REG_SPN0
    && reg_addr <= `DDM_REG_SPN3 && fmi_ok(reg_wdata[23:19]);
  wire [1:0] spn_idx = reg_addr[1:0] - 2'h2;
  // Log has no reset: retention domain carries it across power cycles
  always @(posedge clock)
  begin
    for (n = 0; n < 16; n = n + 1)
      if (pending[n] && occ[n] != 8'h7e)
        occ[n] <= occ[n] + 8'h01;
    if (spn_wr)
    begin
      fmi[spn_idx][sel] <= reg_wdata[23:19];
      if (spn_idx == 2'h0 && spn[0][sel] != reg_wdata[18:0])
        occ[sel] <= 8'h00;
    end
  end

  // ==========================================================
  // Message cues and flags
  reg [15:0] active_q;
  reg        any_d;
  wire       any_active = |active;
  wire [4:0] n_active;
  assign n_active = active[0]+active[1]+active[2]+active[3]+active[4]
    +active[5]+active[6]+active[7]+active[8]+active[9]+active[10]
    +active[11]+active[12]+active[13]+active[14]+active[15];
  reg [1:0] lamp_next;
  reg [3:0] ofault_next;
  reg       sup_next;
  reg       tmp_next;
  always @*
  begin
    lamp_next   = 2'h0;
    ofault_next = 4'h0;
    sup_next    = 1'b0;
    tmp_next    = 1'b0;
    for (m = 0; m < 16; m = m + 1)
    begin
      if (active[m] && cfg[m][8:7] > lamp_next)
        lamp_next = cfg[m][8:7];
      if (raw_fault[m])
      begin
        if (cfg[m][5:2] >= `DDM_SRC_CURR0 && cfg[m][5:2] <= 4'h6)
          ofault_next[cfg[m][3:2] - 2'h3] = 1'b1;
        if (cfg[m][5:2] == `DDM_SRC_SUPPLY)
          sup_next = 1'b1;
        if (cfg[m][5:2] == `DDM_SRC_TEMP)
          tmp_next = 1'b1;
      end
    end
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dm1_send        <= 1'b0;
      dm1_multipacket <= 1'b0;
      dm2_send        <= 1'b0;
      lamp_status     <= 2'h0;
      output_fault    <= 4'h0;
      supply_fault    <= 1'b0;
      temp_fault      <= 1'b0;
      active_q        <= 16'h0000;
      any_d           <= 1'b0;
    end
    else
    begin
      active_q <= active;
      any_d    <= any_active;
      // send on new code or last clear
      dm1_send <= holdoff_done
        && (|(active & ~active_q) || (any_d && !any_active));
      dm1_multipacket <= (n_active > 5'h01);
      dm2_send     <= dm2_request;
      lamp_status  <= lamp_next;
      output_fault <= ofault_next;
      supply_fault <= sup_next;
      temp_fault   <= tmp_next;
    end
  end

  // held off while supply or temperature out of range, each when its enable bit is set
  assign outputs_off = (supply_fault && pwr_dis_en)
    || (temp_fault && temp_dis_en);

  // ==========================================================
  // Register read
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      if (reg_addr == `DDM_REG_CFG)
        reg_rdata <= {19'h00000, cfg[sel]};
      else if (reg_addr == `DDM_REG_ACTIVE)
        reg_rdata <= {16'h0000, active};
      else if (reg_addr == `DDM_REG_PREV)
        reg_rdata <= {16'h0000, prev};
      else if (reg_addr == `DDM_REG_OCC)
        reg_rdata <= {24'h000000, occ[sel]};
      else if (reg_addr == `DDM_REG_STATUS)
        reg_rdata <= {25'h0000000, holdoff_done, outputs_off,
                      temp_fault, supply_fault, lamp_status, 1'b0};
      else if (reg_addr == `DDM_REG_DTC)
        // SPN low, SPN mid, SPN hi+FMI, CM+OC
        reg_rdata <= {1'b0, occ[sel][6:0], spn[fsel][sel][18:16],
                      fmi[fsel][sel], spn[fsel][sel][15:0]};
      else
        reg_rdata <= 32'h00000000;
    end
  end

endmodule

// >>> test/ddm_monitor_chk.sv
// Purpose: Port assertions for the trouble code monitor
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Holdoff bound allows two cycles of counter offset
`timescale 1ns/1ps
`include "ddm_defines.vh"
module ddm_monitor_chk
#(
  parameter HOLDOFF_MS = 5000,
  parameter MS_CYCLES  = `DDM_MS_CYCLES
)
(
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Bus and requests
  input wire reg_wr,
  input wire dm2_request,
  // Cues and flags
  input wire dm1_send,
  input wire dm1_multipacket,
  input wire dm2_send,
  input wire supply_fault,
  input wire temp_fault,
  input wire outputs_off
);
  localparam int LIMIT = HOLDOFF_MS * MS_CYCLES;
  reg [31:0] up_cycles;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Uptime since reset, saturating
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      up_cycles <= 32'h0;
    else if (up_cycles < LIMIT + 8)
      up_cycles <= up_cycles + 32'h1;
  end
  // ==========================================
  // Properties
  dm2_answer_a: assert property (dm2_request |=> dm2_send)
    else $error("dm2 cue missing after request");
  dm2_unasked_a: assert property (dm2_send |-> $past(dm2_request))
    else $error("dm2 cue without request");
  dm1_pulse_a: assert property (dm1_send |=> !dm1_send)
    else $error("dm1 cue longer than one cycle");
  holdoff_quiet_a: assert property (dm1_send |-> up_cycles + 2 >= LIMIT)
    else $error("dm1 cue inside holdoff");
  // Cue trails the active set by up to three cycles
  multi_cue_a: assert property
    (($rose(dm1_multipacket) && up_cycles >= LIMIT + 8) |-> ##[0:3] dm1_send)
    else $error("second code without dm1 cue");
  off_cause_a: assert property
    (outputs_off |-> (supply_fault || temp_fault))
    else $error("outputs off without fault");
  temp_hold_a: assert property
    (($past(outputs_off) && !$past(supply_fault) && $past(temp_fault)
      && temp_fault && !$past(reg_wr)) |-> outputs_off)
    else $error("outputs back on while hot");
  supply_hold_a: assert property
    (($past(outputs_off) && !$past(temp_fault) && $past(supply_fault)
      && supply_fault && !$past(reg_wr)) |-> outputs_off)
    else $error("outputs back on with supply fault");
endmodule

bind ddm_monitor ddm_monitor_chk
  #(.HOLDOFF_MS(HOLDOFF_MS), .MS_CYCLES(MS_CYCLES)) chk
(
  .clock           (clock),
  .rst_n           (rst_n),
  .reg_wr          (reg_wr),
  .dm2_request     (dm2_request),
  .dm1_send        (dm1_send),
  .dm1_multipacket (dm1_multipacket),
  .dm2_send        (dm2_send),
  .supply_fault    (supply_fault),
  .temp_fault      (temp_fault),
  .outputs_off     (outputs_off)
);

// >>> test/ddm_ecu_model.sv
// Purpose: Remote network node issuing requests and counting cues
// Assumes: Bench pulses go for one cycle per request
// Notes:   Kind 1 active clear, 2 previous list, 3 previous clear
`timescale 1ns/1ps
module ddm_ecu_model
(
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Bench command
  input  wire        go,
  input  wire [1:0]  kind,
  // Device side
  input  wire        dm1_send,
  input  wire        dm2_send,
  output reg         dm2_request,
  output reg         dm3_request,
  output reg         dm11_request,
  // Observed traffic
  output reg  [15:0] dm1_count,
  output reg  [15:0] dm2_count
);
  // ==========================================
  // Requests and counters
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dm2_request  <= 1'b0;
      dm3_request  <= 1'b0;
      dm11_request <= 1'b0;
      dm1_count    <= 16'h0;
      dm2_count    <= 16'h0;
    end
    else
    begin
      dm11_request <= go && kind == 2'h1;
      dm2_request  <= go && kind == 2'h2;
      dm3_request  <= go && kind == 2'h3;
      dm1_count    <= dm1_count + {15'h0, dm1_send};
      dm2_count    <= dm2_count + {15'h0, dm2_send};
    end
  end
endmodule

// >>> test/tb_top.sv
// Purpose: Directed bench for the trouble code monitor
// Assumes: Holdoff one millisecond of a shortened millisecond tick
// Notes:   Fixed settle waits cover the few-cycle activation path
`timescale 1ns/1ps
`include "ddm_defines.vh"
module tb_top;
  localparam HOLD_MS = 1;
  localparam TB_MS = 1000;
  reg         clock;
  reg         rst_n;
  reg  [5:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [31:0] reg_rdata;
  reg  [15:0] supply_value;
  reg  [15:0] temp_value;
  reg  [3:0]  timeout_flags;
  reg  [63:0] current_value;
  reg         go;
  reg  [1:0]  kind;
  wire        dm2_request;
  wire        dm3_request;
  wire        dm11_request;
  wire        dm1_send;
  wire        dm1_multipacket;
  wire        dm2_send;
  wire [1:0]  lamp_status;
  wire [3:0]  output_fault;
  wire        supply_fault;
  wire        temp_fault;
  wire        outputs_off;
  wire [15:0] dm1_count;
  wire [15:0] dm2_count;
  reg  [31:0] rdv;
  reg  [15:0] base;
  integer     miscompares;
  integer     cmp_count;

  ddm_monitor #(.HOLDOFF_MS(HOLD_MS), .MS_CYCLES(TB_MS)) dut
  (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .supply_value(supply_value),
    .temp_value(temp_value), .timeout_flags(timeout_flags),
    .current_value(current_value), .dm2_request(dm2_request),
    .dm3_request(dm3_request), .dm11_request(dm11_request),
    .dm1_send(dm1_send), .dm1_multipacket(dm1_multipacket),
    .dm2_send(dm2_send), .lamp_status(lamp_status),
    .output_fault(output_fault), .supply_fault(supply_fault),
    .temp_fault(temp_fault), .outputs_off(outputs_off)
  );
  ddm_ecu_model peer
  (
    .clock(clock), .rst_n(rst_n), .go(go), .kind(kind),
    .dm1_send(dm1_send), .dm2_send(dm2_send),
    .dm2_request(dm2_request), .dm3_request(dm3_request),
    .dm11_request(dm11_request), .dm1_count(dm1_count),
    .dm2_count(dm2_count)
  );

  // ==========================================
  // Access and compare tasks
  task wr(input [5:0] a, input [31:0] d);
  begin
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  end
  endtask
  task chk_reg(input string nm, input [31:0] e, input [31:0] g);
  begin
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("unexpected %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task chk_pin(input string nm, input [3:0] e, input [3:0] g);
  begin
    chk_reg(nm, {28'h0, e}, {28'h0, g});
  end
  endtask
  task rd_chk(input [5:0] a, input [31:0] m, input [31:0] e,
              input string nm);
  begin
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    rdv = reg_rdata;
    chk_reg(nm, e, rdv & m);
  end
  endtask
  task req(input [1:0] k);
  begin
    @(posedge clock);
    go   <= 1'b1;
    kind <= k;
    @(posedge clock);
    go   <= 1'b0;
  end
  endtask
  task settle;
  begin
    repeat (30) @(posedge clock);
    #1;
  end
  endtask
  task give_verdict;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  // ==========================================
  // Clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    #(8 * 10000);
    miscompares = miscompares + 1;
    $display("watchdog expired");
    give_verdict;
  end

  // ==========================================
  // Test sequence
  initial
  begin
    miscompares = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, go, kind} = 0;
    {supply_value, timeout_flags, current_value} = 0;
    temp_value = 16'h0063;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    // Supply shutdown off so only temperature can stop outputs
    wr(`DDM_REG_CTRL, 32'h2);
    wr(`DDM_REG_SEL, 32'h1);
    wr(`DDM_REG_CFG, 32'h305);
    wr(`DDM_REG_THR_LO, 32'h64);
    wr(`DDM_REG_DLY, 32'h0);
    wr(`DDM_REG_SPN0, 32'h123);
    @(posedge clock) temp_value <= 16'h0064;
    settle;
    rd_chk(`DDM_REG_ACTIVE, 32'hffff, 32'h2, "active");
    @(posedge clock) temp_value <= 16'h0063;
    settle;
    rd_chk(`DDM_REG_PREV, 32'hffff, 32'h2, "previous");
    rd_chk(`DDM_REG_STATUS, 32'h40, 32'h0, "holdoff");
    chk_reg("dm1 count", 32'h0, {16'h0, dm1_count});
    $display("test holdoff done");
    repeat (HOLD_MS * TB_MS) @(posedge clock);
    rd_chk(`DDM_REG_STATUS, 32'h40, 32'h40, "holdoff");
    rd_chk(`DDM_REG_DTC, 32'hffffffff, 32'h01000123, "dtc");
    @(posedge clock) temp_value <= 16'h0064;
    settle;
    chk_reg("dm1 count", 32'h1, {16'h0, dm1_count});
    chk_pin("lamp", 4'h2, {2'h0, lamp_status});
    chk_pin("flags", 4'h6, {1'b0, temp_fault, outputs_off,
            dm1_multipacket});
    rd_chk(`DDM_REG_DTC, 32'hffffffff, 32'h02000123, "dtc");
    wr(`DDM_REG_CTRL, 32'h0);
    settle;
    chk_pin("off", 4'h0, {3'h0, outputs_off});
    wr(`DDM_REG_CTRL, 32'h2);
    $display("test activation done");
    wr(`DDM_REG_SEL, 32'h2);
    wr(`DDM_REG_CFG, 32'h2ca);
    wr(`DDM_REG_DLY, 32'h0);
    wr(`DDM_REG_SPN0, 32'h00f80200);
    @(posedge clock) timeout_flags <= 4'h1;
    settle;
    chk_reg("dm1 count", 32'h2, {16'h0, dm1_count});
    chk_pin("multi", 4'h1, {3'h0, dm1_multipacket});
    @(posedge clock) temp_value <= 16'h0063;
    settle;
    chk_pin("flags", 4'h0, {1'b0, temp_fault, outputs_off,
            dm1_multipacket});
    @(posedge clock) timeout_flags <= 4'h0;
    settle;
    rd_chk(`DDM_REG_ACTIVE, 32'hffff, 32'h4, "active");
    base = dm1_count;
    req(2'h1);
    settle;
    rd_chk(`DDM_REG_ACTIVE, 32'hffff, 32'h0, "active");
    chk_reg("dm1 count", {16'h0, base + 16'h1}, {16'h0, dm1_count});
    $display("test latch done");
    req(2'h2);
    settle;
    chk_reg("dm2 count", 32'h1, {16'h0, dm2_count});
    rd_chk(`DDM_REG_PREV, 32'h2, 32'h2, "previous");
    req(2'h3);
    settle;
    rd_chk(`DDM_REG_PREV, 32'hffff, 32'h0, "previous");
    $display("test requests done");
    wr(`DDM_REG_SEL, 32'h3);
    wr(`DDM_REG_CFG, 32'h20d);
    wr(`DDM_REG_THR_LO, 32'h32);
    wr(`DDM_REG_DLY, 32'h0);
    wr(`DDM_REG_SPN0, 32'h00300300);
    wr(`DDM_REG_SPN1, 32'h00280301);
    @(posedge clock) current_value <= 64'h3c;
    settle;
    chk_pin("output fault", 4'h1, output_fault);
    $display("test current done");
    wr(`DDM_REG_SEL, 32'h1);
    wr(`DDM_REG_SPN0, 32'h0);
    rd_chk(`DDM_REG_DTC, 32'h7f000000, 32'h0, "count");
    base = dm1_count;
    @(posedge clock) temp_value <= 16'h0064;
    settle;
    chk_reg("dm1 count", {16'h0, base}, {16'h0, dm1_count});
    rd_chk(`DDM_REG_ACTIVE, 32'h2, 32'h0, "active");
    wr(`DDM_REG_SPN0, 32'h00b00055);
    rd_chk(`DDM_REG_DTC, 32'h00ffffff, 32'h0, "dtc");
    wr(`DDM_REG_SPN0, 32'h00f80055);
    rd_chk(`DDM_REG_DTC, 32'h00ffffff, 32'h001f0055, "dtc");
    $display("test identifiers done");
    wr(`DDM_REG_CTRL, 32'h1);
    wr(`DDM_REG_SEL, 32'h0);
    wr(`DDM_REG_THR_HI, 32'h10);
    @(posedge clock) supply_value <= 16'h0020;
    temp_value <= 16'h0063;
    settle;
    chk_pin("supply", 4'h3, {2'h0, supply_fault, outputs_off});
    @(posedge clock) supply_value <= 16'h0008;
    settle;
    chk_pin("supply", 4'h0, {2'h0, supply_fault, outputs_off});
    wr(`DDM_REG_CFG, 32'h203);
    wr(`DDM_REG_THR_LO, 32'h4);
    wr(`DDM_REG_DLY, 32'h2);
    wr(`DDM_REG_SPN0, 32'h00080777);
    @(posedge clock) supply_value <= 16'h0002;
    settle;
    chk_pin("supply", 4'h3, {2'h0, supply_fault, outputs_off});
    rd_chk(`DDM_REG_ACTIVE, 32'h1, 32'h0, "active");
    repeat (2 * TB_MS) @(posedge clock);
    rd_chk(`DDM_REG_ACTIVE, 32'h1, 32'h1, "active");
    $display("test supply done");
    give_verdict;
  end
endmodule
